// File: common/bswt_pkg.sv
// Purpose: shared constants and types of the bcd stopwatch timer
// Assumes: 8-bit register port, 16-bit byte addresses
// Notes:   every register address, field position, digit limit and vector used by the design is named here
`default_nettype none
package bswt_pkg;
    // --------------------------------------------------------------
    // register map
    // --------------------------------------------------------------
    localparam logic [15:0] ADDR_PRIO  = 16'hff20;
    localparam logic [15:0] ADDR_EN    = 16'hff22;
    localparam logic [15:0] ADDR_FLAG  = 16'hff26;
    localparam logic [15:0] ADDR_CTRL  = 16'hff42;
    localparam logic [15:0] ADDR_COUNT = 16'hff43;

    // --------------------------------------------------------------
    // field positions
    // --------------------------------------------------------------
    localparam int BIT_RUN   = 0;
    localparam int BIT_CLEAR = 1;
    localparam int BIT_PRIO  = 2;
    localparam int BIT_TICK  = 4;
    localparam int NUM_TICK  = 3;

    // --------------------------------------------------------------
    // reset values, digit limits and divider ends
    // --------------------------------------------------------------
    localparam logic [7:0] RST_BYTE  = 8'h00;
    localparam logic [3:0] DIGIT_MAX = 4'h9;
    localparam logic [3:0] DIGIT_ZRO = 4'h0;
    localparam logic [1:0] PRIO_NONE = 2'h0;
    localparam logic [1:0] DIV_TWO   = 2'h1;
    localparam logic [1:0] DIV_THREE = 2'h2;

    // --------------------------------------------------------------
    // tick interrupt vectors
    // --------------------------------------------------------------
    localparam logic [23:0] VEC_HUND = 24'h00002e;
    localparam logic [23:0] VEC_TENS = 24'h000030;
    localparam logic [23:0] VEC_SEC  = 24'h000032;

    // --------------------------------------------------------------
    // run control state, one bit changes per step except stopping to stopped
    // --------------------------------------------------------------
    typedef enum logic [1:0] {
        BSWT_STOPPED  = 2'h0,
        BSWT_RUNNING  = 2'h1,
        BSWT_STOPPING = 2'h3
    } bswt_run_t;

    // tick vector: [0] second, [1] tenths, [2] hundredths
    typedef logic [NUM_TICK-1:0] bswt_tick_t;

    // register port request
    typedef struct packed {
        logic [15:0] addr;
        logic [7:0]  wdata;
        logic        wr;
        logic        rd;
    } bswt_req_t;
endpackage
`default_nettype wire

// File: hdl/bswt_digits.sv
// Purpose: two cascaded bcd digits with feedback 100 hz divider
// Assumes: step is a one-cycle falling 256 hz strobe while running
// Notes:   clear wins over counting
`default_nettype none
module bswt_digits (
    // clock and reset
    input  wire logic              clk,
    input  wire logic              rst_n,
    input  wire logic              ce,
    // control
    input  wire logic              step,
    input  wire logic              clear,
    // results
    output logic [7:0]             value,
    output bswt_pkg::bswt_tick_t   ticks
);
    typedef struct packed {
        logic [1:0] div;
        logic       alt;
        logic [3:0] hund;
        logic [3:0] tens;
    } bswt_dig_t;

    bswt_dig_t s_r;
    bswt_dig_t s_nxt;
    logic      hund_p;
    logic      tens_p;
    logic      sec_p;
    logic [1:0] div_end;

    // --------------------------------------------------------------
    // combinational next state
    // --------------------------------------------------------------
    // 2/256 and 3/256 intervals alternate
    assign div_end = s_r.alt ? bswt_pkg::DIV_THREE : bswt_pkg::DIV_TWO;
    assign hund_p  = step && (s_r.div == div_end);
    assign tens_p  = hund_p && (s_r.hund == bswt_pkg::DIGIT_MAX);
    assign sec_p   = tens_p && (s_r.tens == bswt_pkg::DIGIT_MAX);

    always_comb begin
        s_nxt = s_r;
        if (clear) begin
            s_nxt = '0;
        end else if (step) begin
            s_nxt.div = hund_p ? 2'h0 : 2'(s_r.div + 2'h1);
            if (hund_p) begin
                s_nxt.alt  = ~s_r.alt;
                s_nxt.hund = tens_p ? bswt_pkg::DIGIT_ZRO
                                    : 4'(s_r.hund + 4'h1);
                if (tens_p) begin
                    s_nxt.tens = sec_p ? bswt_pkg::DIGIT_ZRO
                                       : 4'(s_r.tens + 4'h1);
                end
            end
        end
    end

    // --------------------------------------------------------------
    // state register
    // --------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_r <= '0;
        end else if (ce) begin
            s_r <= s_nxt;
        end
    end

    // outputs
    assign value = {s_r.tens, s_r.hund};
    assign ticks = {hund_p, tens_p, sec_p};

    // --------------------------------------------------------------
    // checks
    // --------------------------------------------------------------
    AST_BCD_LEGAL: assert property (
        @(posedge clk) disable iff (!rst_n)
        s_r.hund <= bswt_pkg::DIGIT_MAX && s_r.tens <= bswt_pkg::DIGIT_MAX)
        else $error("bcd digit out of range");
    AST_CLEAR_ZERO: assert property (
        @(posedge clk) disable iff (!rst_n)
        clear && ce |=> value == bswt_pkg::RST_BYTE)
        else $error("clear did not zero count");
    AST_DIV_GAP: assert property (
        @(posedge clk) disable iff (!rst_n)
        hund_p && ce |=> !hund_p)
        else $error("hundredths pulses back to back");
endmodule
`default_nettype wire

// File: hdl/bswt_top.sv
// Purpose: bcd stopwatch timer with registers and tick interrupts
// Assumes: tick_256 is a level synchronous to clk
// Notes:   count advances only on the falling 256 hz strobe
`default_nettype none
module bswt_top (
    // clock and reset
    input  wire logic               clk,
    input  wire logic               resetn,
    input  wire logic               ce,
    // sub oscillator tick
    input  wire logic               tick_256,
    // register port
    input  wire logic [15:0]        addr,
    input  wire logic [7:0]         wdata,
    input  wire logic               wr,
    input  wire logic               rd,
    output logic [7:0]              rdata,
    // cpu interrupt side
    input  wire logic [1:0]         cpu_mask_level,
    output logic                    irq_req,
    output logic [1:0]              irq_level,
    output logic [23:0]             irq_vector
);
    typedef struct packed {
        bswt_pkg::bswt_run_t  run;
        logic                 run_wr;
        logic                 run_val;
        logic                 tick_d;
        logic [1:0]           prio;
        bswt_pkg::bswt_tick_t en;
        bswt_pkg::bswt_tick_t flag;
        logic [7:0]           rdata;
    } bswt_st_t;

    bswt_st_t            s_r;
    bswt_st_t            s_nxt;
    logic [1:0]          rst_sync_r;
    logic                rst_n;
    logic                fall;
    logic                step;
    logic                clear;
    logic [7:0]          value;
    bswt_pkg::bswt_tick_t ticks;
    bswt_pkg::bswt_tick_t pend;
    bswt_pkg::bswt_req_t req;

    // --------------------------------------------------------------
    // reset release
    // --------------------------------------------------------------
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rst_sync_r <= 2'h0;
        end else begin
            rst_sync_r <= {rst_sync_r[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_r[1];

    // request bundle
    assign req = '{addr: addr, wdata: wdata, wr: wr, rd: rd};

    // address match helper
    function automatic logic hit(input logic [15:0] a,
                                 input logic [15:0] b);
        hit = (a == b);
    endfunction

    // --------------------------------------------------------------
    // tick strobe and counting enable
    // --------------------------------------------------------------
    assign fall  = s_r.tick_d && !tick_256;
    // counting on strobe while running or completing the stop step
    assign step  = fall && (s_r.run != bswt_pkg::BSWT_STOPPED);
    assign clear = req.wr && hit(req.addr, bswt_pkg::ADDR_CTRL)
                   && req.wdata[bswt_pkg::BIT_CLEAR];

    bswt_digits u_digits (
        .clk   (clk),
        .rst_n (rst_n),
        .ce    (ce),
        .step  (step),
        .clear (clear),
        .value (value),
        .ticks (ticks)
    );

    // --------------------------------------------------------------
    // combinational next state
    // --------------------------------------------------------------
    always_comb begin
        s_nxt = s_r;
        s_nxt.tick_d = tick_256;
        // run/stop request waits for the next falling tick
        if (req.wr && hit(req.addr, bswt_pkg::ADDR_CTRL)) begin
            s_nxt.run_wr  = 1'b1;
            s_nxt.run_val = req.wdata[bswt_pkg::BIT_RUN];
        end
        if (fall && s_r.run_wr && !(req.wr
            && hit(req.addr, bswt_pkg::ADDR_CTRL))) begin
            s_nxt.run_wr = 1'b0;
        end
        case (s_r.run)
            bswt_pkg::BSWT_STOPPED: begin
                if (fall && s_r.run_wr && s_r.run_val) begin
                    s_nxt.run = bswt_pkg::BSWT_RUNNING;
                end
            end
            bswt_pkg::BSWT_RUNNING: begin
                if (fall && s_r.run_wr && !s_r.run_val) begin
                    s_nxt.run = bswt_pkg::BSWT_STOPPING;
                end
            end
            bswt_pkg::BSWT_STOPPING: begin
                s_nxt.run = bswt_pkg::BSWT_STOPPED;
            end
            default: begin
                s_nxt.run = bswt_pkg::BSWT_STOPPED;
            end
        endcase
        // configuration stores
        if (req.wr && hit(req.addr, bswt_pkg::ADDR_PRIO)) begin
            s_nxt.prio = req.wdata[bswt_pkg::BIT_PRIO +: 2];
        end
        if (req.wr && hit(req.addr, bswt_pkg::ADDR_EN)) begin
            s_nxt.en = req.wdata[bswt_pkg::BIT_TICK +:
                                 bswt_pkg::NUM_TICK];
        end
        // flags: set wins over write-one clear
        for (int i = 0; i < bswt_pkg::NUM_TICK; i++) begin
            if (req.wr && hit(req.addr, bswt_pkg::ADDR_FLAG)
                && req.wdata[bswt_pkg::BIT_TICK + i]) begin
                s_nxt.flag[i] = 1'b0;
            end
            if (ticks[i]) begin
                s_nxt.flag[i] = 1'b1;
            end
        end
        // read data, valid one cycle after rd; count byte is read-only
        s_nxt.rdata = bswt_pkg::RST_BYTE;
        if (req.rd) begin
            if (hit(req.addr, bswt_pkg::ADDR_PRIO)) begin
                s_nxt.rdata[bswt_pkg::BIT_PRIO +: 2] = s_r.prio;
            end else if (hit(req.addr, bswt_pkg::ADDR_EN)) begin
                s_nxt.rdata[bswt_pkg::BIT_TICK +:
                            bswt_pkg::NUM_TICK] = s_r.en;
            end else if (hit(req.addr, bswt_pkg::ADDR_FLAG)) begin
                s_nxt.rdata[bswt_pkg::BIT_TICK +:
                            bswt_pkg::NUM_TICK] = s_r.flag;
            end else if (hit(req.addr, bswt_pkg::ADDR_CTRL)) begin
                // run reads back as written, a pending start too
                // stays one until the stop is done; clear reads zero
                s_nxt.rdata[bswt_pkg::BIT_RUN] =
                    (s_r.run != bswt_pkg::BSWT_STOPPED)
                    || (s_r.run_wr && s_r.run_val);
            end else if (hit(req.addr, bswt_pkg::ADDR_COUNT)) begin
                s_nxt.rdata = value;
            end
        end
    end

    // --------------------------------------------------------------
    // state register
    // --------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_r <= '0;
        end else if (ce) begin
            s_r <= s_nxt;
        end
    end

    // --------------------------------------------------------------
    // interrupt request and vector
    // --------------------------------------------------------------
    assign pend = s_r.flag & s_r.en;
    assign irq_req = (|pend) && (s_r.prio > cpu_mask_level);
    assign irq_level = s_r.prio;
    assign irq_vector = pend[2] ? bswt_pkg::VEC_HUND :
                        pend[1] ? bswt_pkg::VEC_TENS :
                        pend[0] ? bswt_pkg::VEC_SEC : 24'h000000;
    assign rdata = s_r.rdata;

    // --------------------------------------------------------------
    // checks
    // --------------------------------------------------------------
    AST_IRQ_GATE: assert property (
        @(posedge clk) disable iff (!rst_n)
        irq_req |-> (|(s_r.flag & s_r.en)) && irq_level > cpu_mask_level
        && irq_vector != 24'h000000)
        else $error("request without cause");
    AST_FLAG_SET: assert property (
        @(posedge clk) disable iff (!rst_n)
        ce && ticks[0] |=> s_r.flag[0])
        else $error("second flag not set");
    AST_FLAG_CLR: assert property (
        @(posedge clk) disable iff (!rst_n)
        ce && wr && addr == bswt_pkg::ADDR_FLAG
        && wdata[bswt_pkg::BIT_TICK + 2] && !ticks[2]
        |=> !s_r.flag[2])
        else $error("flag not cleared");
    AST_HOLD: assert property (
        @(posedge clk) disable iff (!rst_n)
        s_r.run == bswt_pkg::BSWT_STOPPED && !clear |=> $stable(value))
        else $error("count moved while stopped");
    AST_STOP_STEP: assert property (
        @(posedge clk) disable iff (!rst_n)
        ce && s_r.run == bswt_pkg::BSWT_STOPPING
        |=> s_r.run == bswt_pkg::BSWT_STOPPED)
        else $error("stop did not complete");
    AST_CTRL_READ: assert property (
        @(posedge clk) disable iff (!rst_n)
        ce && rd && addr == bswt_pkg::ADDR_CTRL |=> rdata[7:1] == 7'h00)
        else $error("control upper bits not zero");
    AST_VEC: assert property (
        @(posedge clk) disable iff (!rst_n)
        irq_req && pend[2] |-> irq_vector == bswt_pkg::VEC_HUND)
        else $error("wrong vector");
    AST_COUNT_RO: assert property (
        @(posedge clk) disable iff (!rst_n)
        ce && wr && addr == bswt_pkg::ADDR_COUNT && !step |=> $stable(value))
        else $error("count byte was written");
    // a start written but not yet applied already reads one
    AST_RUN_READ: assert property (
        @(posedge clk) disable iff (!rst_n)
        ce && rd && addr == bswt_pkg::ADDR_CTRL && s_r.run_wr && s_r.run_val
        |=> rdata[bswt_pkg::BIT_RUN])
        else $error("pending start reads zero");
    // read data stand one cycle only, then idle at zero
    AST_RDATA_IDLE: assert property (
        @(posedge clk) disable iff (!rst_n)
        ce && !rd |=> rdata == bswt_pkg::RST_BYTE)
        else $error("read data outside read cycle");
endmodule
`default_nettype wire

// File: tb/bswt_tick_src.sv
// Purpose: sub oscillator tick source for the stopwatch bench
// Assumes: tick level changes just after a rising clk edge
// Notes:   period shortened to 2*HALF clk cycles
`default_nettype none
module bswt_tick_src #(
    parameter int HALF = 16
) (
    // clock and reset
    input  wire logic clk,
    input  wire logic rst_n,
    // tick level
    output logic      tick_256
);
    timeunit 1ns;
    timeprecision 100ps;

    int cnt;

    // square wave, held low in reset so no early falling edge
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt <= 0;
            tick_256 <= 1'b0;
        end else if (cnt == HALF - 1) begin
            cnt <= 0;
            tick_256 <= ~tick_256;
        end else begin
            cnt <= cnt + 1;
        end
    end
endmodule
`default_nettype wire

// File: tb/bswt_tb_top.sv
// Purpose: self-checking bench of the bcd stopwatch timer
// Assumes: accesses fit in the low half of the tick after a fall
// Notes:   reference model steps on the same falling tick samples
`default_nettype none
module bswt_tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    // ------------------------------------------------------------
    // signals and model state
    // ------------------------------------------------------------
    logic        clk            = 1'b0;
    logic        resetn         = 1'b0;
    logic        tick_256;
    logic [15:0] addr           = 16'h0000;
    logic [7:0]  wdata          = 8'h00;
    logic        wr             = 1'b0;
    logic        rd             = 1'b0;
    logic [1:0]  cpu_mask_level = 2'h0;
    logic        ce             = 1'b1;
    logic [7:0]  rdata;
    logic        irq_req;
    logic [1:0]  irq_level;
    logic [23:0] irq_vector;
    logic        tk_q           = 1'b0;
    logic [7:0]  pr             = 8'h00;
    logic [7:0]  en             = 8'h00;
    logic [7:0]  fl             = 8'h00;
    int          errors         = 0;
    int          cmp_count      = 0;
    int          seed           = 44702;
    int          h = 0, t = 0, dc = 0, dl = 2, runq = 0, st = 0;
    event        stb_ev;

    always #4 clk = ~clk;

    bswt_top bswt_top_inst (
        .clk(clk), .resetn(resetn), .ce(ce), .tick_256(tick_256),
        .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
        .cpu_mask_level(cpu_mask_level), .irq_req(irq_req),
        .irq_level(irq_level), .irq_vector(irq_vector)
    );

    bswt_tick_src #(.HALF(16)) bswt_tick_src_inst (
        .clk(clk), .rst_n(resetn), .tick_256(tick_256)
    );
    // ------------------------------------------------------------
    // reference model
    // ------------------------------------------------------------
    // one falling tick: count if running, then apply run request
    function automatic void m_strobe();
        if (st != 0) begin
            dc++;
            if (dc == dl) begin
                dc = 0;
                dl = 5 - dl;
                fl[6] = 1'b1;
                h++;
                if (h == 10) begin
                    h = 0;
                    fl[5] = 1'b1;
                    t++;
                    if (t == 10) begin
                        t = 0;
                        fl[4] = 1'b1;
                    end
                end
            end
        end
        st = runq;
    endfunction

    function automatic void m_write(input logic [15:0] a,
                                    input logic [7:0] d);
        case (a)
            bswt_pkg::ADDR_PRIO: pr = d & 8'h0c;
            bswt_pkg::ADDR_EN:   en = d & 8'h70;
            bswt_pkg::ADDR_FLAG: fl = fl & ~(d & 8'h70);
            bswt_pkg::ADDR_CTRL: begin
                runq = d[0];
                if (d[1]) begin
                    h = 0;
                    t = 0;
                    dc = 0;
                    dl = 2;
                end
            end
            default: ;
        endcase
    endfunction

    function automatic logic [7:0] m_read(input logic [15:0] a);
        case (a)
            bswt_pkg::ADDR_PRIO:  return pr;
            bswt_pkg::ADDR_EN:    return en;
            bswt_pkg::ADDR_FLAG:  return fl;
            bswt_pkg::ADDR_CTRL:  return {7'h00, 1'(runq | st)};
            bswt_pkg::ADDR_COUNT: return {4'(t), 4'(h)};
            default:              return 8'h00;
        endcase
    endfunction

    // falling tick seen on the same samples as the design
    always @(posedge clk) begin
        if (resetn && tk_q && !tick_256) begin
            m_strobe();
            -> stb_ev;
        end
        tk_q <= tick_256;
    end
    // ------------------------------------------------------------
    // bus tasks and checks
    // ------------------------------------------------------------
    task automatic chk(input logic [23:0] g, input logic [23:0] e);
        cmp_count++;
        if (g !== e) begin
            errors++;
            $display("unexpected at %0t: got %h exp %h", $time, g, e);
        end
    endtask

    task automatic wr_reg(input logic [15:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        m_write(a, d);
    endtask

    task automatic rd_reg(input logic [15:0] a);
        logic [7:0] e;
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        e = m_read(a);
        @(negedge clk);
        chk({16'h0000, rdata}, {16'h0000, e});
    endtask

    task automatic chk_irq();
        logic [7:0] p;
        p = fl & en;
        @(negedge clk);
        chk({23'h0, irq_req},
            {23'h0, |p && pr[3:2] > cpu_mask_level});
        chk({22'h0, irq_level}, {22'h0, pr[3:2]});
        chk(irq_vector, p[6] ? bswt_pkg::VEC_HUND : p[5] ?
            bswt_pkg::VEC_TENS : p[4] ? bswt_pkg::VEC_SEC : 24'h0);
    endtask

    // wait for falling ticks, then let the design settle
    task automatic steps(input int n);
        repeat (n) begin
            @(stb_ev);
            repeat (3) @(posedge clk);
        end
    endtask

    task automatic results();
        $display("errors %0d comparisons %0d", errors, cmp_count);
        if (errors == 0 && cmp_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (5) @(posedge clk);
        resetn <= 1'b1;
        repeat (3) @(posedge clk);
        // reset values and an unmapped place
        rd_reg(bswt_pkg::ADDR_COUNT);
        rd_reg(bswt_pkg::ADDR_CTRL);
        rd_reg(bswt_pkg::ADDR_PRIO);
        rd_reg(bswt_pkg::ADDR_EN);
        rd_reg(bswt_pkg::ADDR_FLAG);
        rd_reg(16'hff44);
        chk_irq();
        // start with unused bits set, count and flag every tick
        steps(1);
        wr_reg(bswt_pkg::ADDR_CTRL, 8'hfd);
        rd_reg(bswt_pkg::ADDR_CTRL);
        for (int i = 0; i < 40; i++) begin
            steps(1);
            rd_reg(bswt_pkg::ADDR_COUNT);
            rd_reg(bswt_pkg::ADDR_FLAG);
            wr_reg(bswt_pkg::ADDR_FLAG, 8'h40);
        end
        wr_reg(bswt_pkg::ADDR_COUNT, 8'($random(seed)));
        rd_reg(bswt_pkg::ADDR_COUNT);
        // stop takes one more count, then holds
        wr_reg(bswt_pkg::ADDR_CTRL, 8'h00);
        rd_reg(bswt_pkg::ADDR_CTRL);
        steps(1);
        rd_reg(bswt_pkg::ADDR_CTRL);
        rd_reg(bswt_pkg::ADDR_COUNT);
        steps(4);
        rd_reg(bswt_pkg::ADDR_COUNT);
        // clear while stopped, resume, clear while running
        wr_reg(bswt_pkg::ADDR_CTRL, 8'h02);
        rd_reg(bswt_pkg::ADDR_CTRL);
        steps(2);
        rd_reg(bswt_pkg::ADDR_COUNT);
        wr_reg(bswt_pkg::ADDR_CTRL, 8'h01);
        steps(12);
        rd_reg(bswt_pkg::ADDR_COUNT);
        wr_reg(bswt_pkg::ADDR_CTRL, 8'h01);
        rd_reg(bswt_pkg::ADDR_COUNT);
        wr_reg(bswt_pkg::ADDR_CTRL, 8'h03);
        rd_reg(bswt_pkg::ADDR_COUNT);
        steps(7);
        rd_reg(bswt_pkg::ADDR_COUNT);
        // run past a full second for every carry
        wr_reg(bswt_pkg::ADDR_FLAG, 8'h70);
        for (int i = 0; i < 270; i++) begin
            steps(1);
            if (i % 15 == 0) rd_reg(bswt_pkg::ADDR_COUNT);
        end
        rd_reg(bswt_pkg::ADDR_FLAG);
        // software stops before any sleep
        wr_reg(bswt_pkg::ADDR_CTRL, 8'h00);
        steps(2);
        rd_reg(bswt_pkg::ADDR_CTRL);
        // random priority, enables and mask with flags pending
        for (int i = 0; i < 16; i++) begin
            if (i == 8) wr_reg(bswt_pkg::ADDR_FLAG, 8'h40);
            wr_reg(bswt_pkg::ADDR_PRIO, 8'($random(seed)) & 8'h0c);
            wr_reg(bswt_pkg::ADDR_EN, 8'($random(seed)) & 8'h70);
            cpu_mask_level <= 2'($random(seed));
            chk_irq();
            rd_reg(bswt_pkg::ADDR_EN);
        end
        // write zero keeps flags, write one clears them
        wr_reg(bswt_pkg::ADDR_FLAG, 8'h00);
        rd_reg(bswt_pkg::ADDR_FLAG);
        wr_reg(bswt_pkg::ADDR_FLAG, 8'h70);
        chk_irq();
        // a write with the clock enable low is not taken
        @(posedge clk);
        ce <= 1'b0;
        addr <= bswt_pkg::ADDR_PRIO;
        wdata <= ~pr;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        ce <= 1'b1;
        rd_reg(bswt_pkg::ADDR_PRIO);
        // second reset while stopped clears the held count and setup
        resetn <= 1'b0;
        pr = 8'h00;
        en = 8'h00;
        fl = 8'h00;
        h = 0;
        t = 0;
        dc = 0;
        dl = 2;
        runq = 0;
        st = 0;
        repeat (5) @(posedge clk);
        resetn <= 1'b1;
        repeat (3) @(posedge clk);
        rd_reg(bswt_pkg::ADDR_COUNT);
        rd_reg(bswt_pkg::ADDR_CTRL);
        rd_reg(bswt_pkg::ADDR_PRIO);
        rd_reg(bswt_pkg::ADDR_EN);
        rd_reg(bswt_pkg::ADDR_FLAG);
        chk_irq();
        results();
    end

    // watchdog against a hung sequence
    initial begin
        repeat (40000) @(posedge clk);
        errors++;
        results();
    end
endmodule
`default_nettype wire
